// ---- logic/lbbs_pkg.sv ----
// Constants, register map and carrier types for the LED bank setup block
package lbbs_pkg;

    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam int         REG_N            = 7;
    localparam logic [7:0] OFS_SINK_ASSIGN  = 8'h10;
    localparam logic [7:0] OFS_SINK_FB      = 8'h19;
    localparam logic [7:0] OFS_BOOST        = 8'h1A;
    localparam logic [7:0] OFS_PWM_CFG      = 8'h1C;
    localparam logic [7:0] OFS_BRT_LOW      = 8'h20;
    localparam logic [7:0] OFS_BRT_HIGH     = 8'h21;
    localparam logic [7:0] OFS_BANK_EN      = 8'h24;
    localparam int         IDX_SINK_ASSIGN  = 0;
    localparam int         IDX_SINK_FB      = 1;
    localparam int         IDX_BOOST        = 2;
    localparam int         IDX_PWM_CFG      = 3;
    localparam int         IDX_BRT_LOW      = 4;
    localparam int         IDX_BRT_HIGH     = 5;
    localparam int         IDX_BANK_EN      = 6;
    localparam logic [REG_N-1:0][7:0] REG_OFS = {OFS_BANK_EN, OFS_BRT_HIGH, OFS_BRT_LOW,
        OFS_PWM_CFG, OFS_BOOST, OFS_SINK_FB, OFS_SINK_ASSIGN};
    // Boost value 8'h00 gives the 16 V threshold and 500 kHz
    localparam logic [REG_N-1:0][7:0] REG_RST = {REG_N{8'h00}};
    localparam logic [7:0] RD_UNMAPPED      = 8'h00;

    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int BOOST_FREQ_BIT = 0;
    localparam int BOOST_OVP_LSB  = 1;
    localparam int PWM_A_BIT      = 0;
    localparam int PWM_B_BIT      = 1;
    localparam int PWM_POL_BIT    = 2;
    localparam int PWM_ZD_BIT     = 3;
    localparam int BANK_A_BIT     = 0;
    localparam int BANK_B_BIT     = 1;
    localparam int LOW_BITS       = 3;
    localparam int BRT_W          = 11;

    // --------------------------------------------------------------
    // Timing and defaults
    // --------------------------------------------------------------
    localparam int         CLK_MHZ         = 100;
    localparam int         RAMP_TIME_US    = 2048;
    localparam int         RAMP_CYCLES_DEF = RAMP_TIME_US * CLK_MHZ;
    localparam int         BRT_STEPS       = 2048;
    localparam int         STEP_W          = 24;
    localparam logic [2:0] RAMP_CODE_RST   = 3'h5;
    localparam logic       MAP_EXP_RST     = 1'b1;
    localparam logic [4:0] FS_CODE_RST     = 5'h13;

    // --------------------------------------------------------------
    // Types
    // --------------------------------------------------------------
    typedef enum logic [3:0] {
        BS_IDLE, BS_ADDR, BS_ADDR_ACK, BS_PTR, BS_PTR_ACK,
        BS_WDATA, BS_WDATA_ACK, BS_RDATA, BS_RDATA_ACK
    } lbbs_bus_st_type;

    typedef struct packed {
        logic [2:0]       sink_to_bank_b;
        logic [2:0]       sink_fb_en;
        logic [1:0]       ovp_sel;
        logic             sw_freq_1mhz;
        logic             pwm_zero_det;
        logic             pwm_act_high;
        logic             pwm_bank_b_en;
        logic             pwm_bank_a_en;
        logic             bank_a_en;
        logic             bank_b_en;
        logic [BRT_W-1:0] bank_a_level;
        logic [2:0]       ramp_code;
        logic             map_exponential;
        logic [4:0]       full_scale_code;
    } lbbs_cfg_type;

    typedef struct packed {
        logic                    scl_p;
        logic                    sda_p;
        lbbs_bus_st_type         st;
        logic [3:0]              cnt;
        logic [7:0]              shf;
        logic                    rw;
        logic                    ack_ok;
        logic [7:0]              ptr;
        logic                    sda_o;
        logic                    sda_oe;
        logic [REG_N-1:0][7:0]   regs;
        logic [BRT_W-1:0]        target;
        logic [BRT_W-1:0]        level;
        logic [STEP_W-1:0]       step_cnt;
        logic [2:0]              ramp_code;
        logic                    map_exp;
        logic [4:0]              fs_code;
    } lbbs_state_type;

endpackage

// ---- logic/lbbs_core.sv ----
// Serial register bank and bank A brightness update logic of the LED driver
`timescale 1ns/10ps

module lbbs_core
    import lbbs_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR    = 7'h36,
    parameter int         RAMP_CYCLES = RAMP_CYCLES_DEF
)
(
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         srst,
    // Serial register port, open drain data
    input  wire logic         scl_in,
    input  wire logic         sda_in,
    output logic              sda_o,
    output logic              sda_oe,
    // Configuration towards the analog side
    output lbbs_cfg_type      cfg
);

    // --------------------------------------------------------------
    // Ramp pacing
    // --------------------------------------------------------------
    // One code step per interval so a full-scale sweep lasts the ramp time
    localparam int                STEP_CYCLES = RAMP_CYCLES / BRT_STEPS;
    localparam logic [STEP_W-1:0] STEP_LAST   = STEP_W'(STEP_CYCLES - 1);

    generate
        if (STEP_CYCLES < 1 || STEP_CYCLES > (1 << (STEP_W - 1)))
        begin : g_bad_ramp
            $error("RAMP_CYCLES out of range for the step counter");
        end
    endgenerate

    localparam lbbs_state_type STATE_RST = '{
        scl_p    : 1'b1,
        sda_p    : 1'b1,
        st       : BS_IDLE,
        cnt      : 4'h0,
        shf      : 8'h00,
        rw       : 1'b0,
        ack_ok   : 1'b0,
        ptr      : 8'h00,
        sda_o    : 1'b0,
        sda_oe   : 1'b0,
        regs     : REG_RST,
        target   : 11'h000,
        level    : 11'h000,
        step_cnt : {STEP_W{1'b0}},
        ramp_code: RAMP_CODE_RST,
        map_exp  : MAP_EXP_RST,
        fs_code  : FS_CODE_RST
    };

    lbbs_state_type s_reg;
    lbbs_state_type s_next;
    logic           scl_rise;
    logic           scl_fall;
    logic           bus_start;
    logic           bus_stop;
    logic [7:0]     rd_byte;

    // --------------------------------------------------------------
    // Line events
    // --------------------------------------------------------------
    assign scl_rise  = scl_in & ~s_reg.scl_p;
    assign scl_fall  = ~scl_in & s_reg.scl_p;
    assign bus_start = scl_in & s_reg.scl_p & s_reg.sda_p & ~sda_in;
    assign bus_stop  = scl_in & s_reg.scl_p & ~s_reg.sda_p & sda_in;

    always_comb
    begin
        rd_byte = RD_UNMAPPED;
        for (int i = 0; i < REG_N; i++)
        begin
            if (s_reg.ptr == REG_OFS[i])
            begin
                rd_byte = s_reg.regs[i];
            end
        end
    end

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb
    begin
        s_next       = s_reg;
        s_next.scl_p = scl_in;
        s_next.sda_p = sda_in;

        // Read bytes shift on the falling edge only, so a rise there just counts
        if (scl_rise)
        begin
            s_next.cnt = s_reg.cnt + 4'h1;
            if (s_reg.st != BS_RDATA)
            begin
                s_next.shf = {s_reg.shf[6:0], sda_in};
            end
        end

        case (s_reg.st)
            BS_IDLE:
            begin
                s_next.sda_oe = 1'b0;
            end
            BS_ADDR:
            begin
                if (scl_fall && s_reg.cnt == 4'h8)
                begin
                    s_next.cnt = 4'h0;
                    if (s_reg.shf[7:1] == DEV_ADDR)
                    begin
                        s_next.rw     = s_reg.shf[0];
                        s_next.sda_oe = 1'b1;
                        s_next.st     = BS_ADDR_ACK;
                    end
                    else
                    begin
                        s_next.st = BS_IDLE;
                    end
                end
            end
            BS_ADDR_ACK:
            begin
                if (scl_fall)
                begin
                    s_next.cnt = 4'h0;
                    if (s_reg.rw)
                    begin
                        s_next.sda_oe = ~rd_byte[7];
                        s_next.shf    = {rd_byte[6:0], 1'b0};
                        s_next.ptr    = s_reg.ptr + 8'h01;
                        s_next.st     = BS_RDATA;
                    end
                    else
                    begin
                        s_next.sda_oe = 1'b0;
                        s_next.st     = BS_PTR;
                    end
                end
            end
            BS_PTR:
            begin
                if (scl_fall && s_reg.cnt == 4'h8)
                begin
                    s_next.ptr    = s_reg.shf;
                    s_next.cnt    = 4'h0;
                    s_next.sda_oe = 1'b1;
                    s_next.st     = BS_PTR_ACK;
                end
            end
            BS_PTR_ACK, BS_WDATA_ACK:
            begin
                if (scl_fall)
                begin
                    s_next.sda_oe = 1'b0;
                    s_next.cnt    = 4'h0;
                    s_next.st     = BS_WDATA;
                end
            end
            BS_WDATA:
            begin
                if (scl_fall && s_reg.cnt == 4'h8)
                begin
                    for (int i = 0; i < REG_N; i++)
                    begin
                        if (s_reg.ptr == REG_OFS[i])
                        begin
                            s_next.regs[i] = s_reg.shf;
                        end
                    end
                    // Only the high byte write moves the held low bits into the target
                    if (s_reg.ptr == OFS_BRT_HIGH)
                    begin
                        s_next.target = {s_reg.shf, s_reg.regs[IDX_BRT_LOW][LOW_BITS-1:0]};
                    end
                    s_next.ptr    = s_reg.ptr + 8'h01;
                    s_next.cnt    = 4'h0;
                    s_next.sda_oe = 1'b1;
                    s_next.st     = BS_WDATA_ACK;
                end
            end
            BS_RDATA:
            begin
                if (scl_fall)
                begin
                    if (s_reg.cnt == 4'h8)
                    begin
                        s_next.sda_oe = 1'b0;
                        s_next.cnt    = 4'h0;
                        s_next.st     = BS_RDATA_ACK;
                    end
                    else
                    begin
                        s_next.sda_oe = ~s_reg.shf[7];
                        s_next.shf    = {s_reg.shf[6:0], 1'b0};
                    end
                end
            end
            BS_RDATA_ACK:
            begin
                if (scl_rise)
                begin
                    s_next.ack_ok = ~sda_in;
                end
                if (scl_fall)
                begin
                    s_next.cnt = 4'h0;
                    if (s_reg.ack_ok)
                    begin
                        s_next.sda_oe = ~rd_byte[7];
                        s_next.shf    = {rd_byte[6:0], 1'b0};
                        s_next.ptr    = s_reg.ptr + 8'h01;
                        s_next.st     = BS_RDATA;
                    end
                    else
                    begin
                        s_next.st = BS_IDLE;
                    end
                end
            end
            default:
            begin
                s_next.st = BS_IDLE;
            end
        endcase

        // Start and stop override any phase so a confused master can resync
        if (bus_start)
        begin
            s_next.st     = BS_ADDR;
            s_next.cnt    = 4'h0;
            s_next.sda_oe = 1'b0;
        end
        else if (bus_stop)
        begin
            s_next.st     = BS_IDLE;
            s_next.sda_oe = 1'b0;
        end

        // ----------------------------------------------------------
        // Brightness ramp
        // ----------------------------------------------------------
        if (s_reg.regs[IDX_PWM_CFG][PWM_A_BIT])
        begin
            // Full 11-bit control: target is taken as is
            s_next.level    = s_reg.target;
            s_next.step_cnt = {STEP_W{1'b0}};
        end
        else if (s_reg.step_cnt == STEP_LAST)
        begin
            s_next.step_cnt = {STEP_W{1'b0}};
            if (s_reg.level < s_reg.target)
            begin
                s_next.level = s_reg.level + 11'h001;
            end
            else if (s_reg.level > s_reg.target)
            begin
                s_next.level = s_reg.level - 11'h001;
            end
        end
        else
        begin
            s_next.step_cnt = s_reg.step_cnt + {{(STEP_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            s_reg <= STATE_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // --------------------------------------------------------------
    // Outputs, all taken from state bits
    // --------------------------------------------------------------
    assign sda_o                = s_reg.sda_o;
    assign sda_oe               = s_reg.sda_oe;
    assign cfg.sink_to_bank_b   = s_reg.regs[IDX_SINK_ASSIGN][2:0];
    assign cfg.sink_fb_en       = s_reg.regs[IDX_SINK_FB][2:0];
    assign cfg.ovp_sel          = s_reg.regs[IDX_BOOST][BOOST_OVP_LSB+1:BOOST_OVP_LSB];
    assign cfg.sw_freq_1mhz     = s_reg.regs[IDX_BOOST][BOOST_FREQ_BIT];
    assign cfg.pwm_zero_det     = s_reg.regs[IDX_PWM_CFG][PWM_ZD_BIT];
    assign cfg.pwm_act_high     = s_reg.regs[IDX_PWM_CFG][PWM_POL_BIT];
    assign cfg.pwm_bank_b_en    = s_reg.regs[IDX_PWM_CFG][PWM_B_BIT];
    assign cfg.pwm_bank_a_en    = s_reg.regs[IDX_PWM_CFG][PWM_A_BIT];
    assign cfg.bank_a_en        = s_reg.regs[IDX_BANK_EN][BANK_A_BIT];
    assign cfg.bank_b_en        = s_reg.regs[IDX_BANK_EN][BANK_B_BIT];
    assign cfg.bank_a_level     = s_reg.level;
    assign cfg.ramp_code        = s_reg.ramp_code;
    assign cfg.map_exponential  = s_reg.map_exp;
    assign cfg.full_scale_code  = s_reg.fs_code;

endmodule // lbbs_core

// ---- test/lbbs_core_assertions.sv ----
// Port checks for the LED bank setup core
`timescale 1ns/10ps

module lbbs_chk
    import lbbs_pkg::*;
(
    // Clock and reset
    input wire logic         clk_sys,
    input wire logic         srst,
    // Serial port
    input wire logic         scl_in,
    input wire logic         sda_in,
    input wire logic         sda_o,
    input wire logic         sda_oe,
    // Configuration
    input wire lbbs_cfg_type cfg
);
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    reset_clear_a: assert property ($fell(srst) |->
        cfg.ovp_sel == 2'h0 && cfg.bank_a_level == 11'h0) else $error("reset not cleared");
    fixed_codes_a: assert property (cfg.ramp_code == RAMP_CODE_RST &&
        cfg.map_exponential && cfg.full_scale_code == FS_CODE_RST) else $error("fixed codes");
    ramp_step_a: assert property (!cfg.pwm_bank_a_en && !$past(cfg.pwm_bank_a_en) &&
        $changed(cfg.bank_a_level) |-> cfg.bank_a_level - $past(cfg.bank_a_level) == 11'h1
        || $past(cfg.bank_a_level) - cfg.bank_a_level == 11'h1) else $error("ramp jump");
    direct_level_a: assert property (cfg.pwm_bank_a_en && $past(cfg.pwm_bank_a_en) &&
        $changed(cfg.bank_a_level) |-> !$past(scl_in, 2)) else $error("level moved unasked");
    oe_rise_a: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
        else $error("data driven with clock high");
    oe_hold_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("data moved with clock high");
    cfg_on_fall_a: assert property ($changed({cfg.sink_to_bank_b, cfg.sink_fb_en,
        cfg.ovp_sel, cfg.pwm_bank_a_en, cfg.bank_a_en}) |-> !$past(scl_in) && $past(scl_in, 2))
        else $error("register changed off a write");
    sda_low_a: assert property (sda_o == 1'b0) else $error("data output not low");

    ramp_seen_c: cover property (!cfg.pwm_bank_a_en && $changed(cfg.bank_a_level));
    direct_seen_c: cover property (cfg.pwm_bank_a_en && $changed(cfg.bank_a_level));
    ack_seen_c: cover property ($rose(sda_oe));
endmodule // lbbs_chk

// ---- test/lbbs_host.sv ----
// Host controller model on the serial register port
`timescale 1ns/10ps

module lbbs_host #(
    parameter logic [6:0] ADDR = 7'h36
)
(
    // Clock
    input  wire logic clk_sys,
    // Serial port, data open drain
    input  wire logic sda_oe,
    output logic      scl_in,
    output logic      sda_in
);
    logic sda_drv;

    // Pull-up: a released line reads high
    assign sda_in = sda_drv & ~sda_oe;
    initial {scl_in, sda_drv} = 2'b11;

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Data moves only while the clock is low
    task automatic bitx(input logic b, output logic r);
        scl_in <= 1'b0;
        tick(2);
        sda_drv <= b;
        tick(2);
        scl_in <= 1'b1;
        tick(2);
        r = sda_in;
        tick(2);
    endtask

    task automatic start();
        sda_drv <= 1'b0;
        tick(4);
    endtask

    task automatic stop();
        scl_in <= 1'b0;
        tick(2);
        sda_drv <= 1'b0;
        tick(2);
        scl_in <= 1'b1;
        tick(4);
        sda_drv <= 1'b1;
        tick(4);
    endtask

    task automatic put(input logic [7:0] d, inout logic ok);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(d[i], r);
        bitx(1'b1, r);
        ok = ok & ~r;
    endtask

    task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
        ok = 1'b1;
        start();
        put({ADDR, 1'b0}, ok);
        put(p, ok);
        put(d, ok);
        stop();
    endtask

    // Pointer write, then one byte read closed by a nack
    task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
        logic r;
        ok = 1'b1;
        start();
        put({ADDR, 1'b0}, ok);
        put(p, ok);
        stop();
        start();
        put({ADDR, 1'b1}, ok);
        for (int i = 7; i >= 0; i--)
            bitx(1'b1, d[i]);
        bitx(1'b1, r);
        stop();
    endtask

    // Pointer write, then two bytes read, the first acked and the second nacked
    task automatic rd2(input logic [7:0] p, output logic [15:0] d, output logic ok);
        logic r;
        ok = 1'b1;
        start();
        put({ADDR, 1'b0}, ok);
        put(p, ok);
        stop();
        start();
        put({ADDR, 1'b1}, ok);
        for (int i = 15; i >= 0; i--)
        begin
            bitx(1'b1, d[i]);
            if (i == 8)
                bitx(1'b0, r);
        end
        bitx(1'b1, r);
        stop();
    endtask
endmodule // lbbs_host

// ---- test/testbench.sv ----
// Self-checking bench for the LED bank setup core
`timescale 1ns/10ps

`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
    $display("BAD %s exp %0h got %0h", n, e, a); end end

module testbench;
    import lbbs_pkg::*;

    logic         clk_sys;
    logic         srst;
    logic         scl_in;
    logic         sda_in;
    logic         sda_o;
    logic         sda_oe;
    lbbs_cfg_type cfg;
    int           mismatches;
    int           cmp_count;
    int           mdl [256];
    int           lvl;
    logic [31:0]  lfsr_reg;
    logic         ok;
    logic [7:0]   rdat;
    logic [15:0]  rdat2;
    logic [7:0]   h;
    logic [7:0]   l;

    // Short ramp: two clocks per code
    lbbs_core #(.RAMP_CYCLES(4096)) u_dut (.clk_sys(clk_sys), .srst(srst), .scl_in(scl_in),
        .sda_in(sda_in), .sda_o(sda_o), .sda_oe(sda_oe), .cfg(cfg));
    lbbs_host u_host (.clk_sys(clk_sys), .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    function automatic logic [7:0] rnd();
        lfsr_reg = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
        return lfsr_reg[7:0];
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic do_reset();
        srst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        foreach (mdl[i])
            mdl[i] = 0;
        lvl = 0;
    endtask

    // Unmapped offsets are acked but keep nothing
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        u_host.wr(p, d, ok);
        `CHK("write ack", 1'b1, ok)
        for (int i = 0; i < REG_N; i++)
            if (REG_OFS[i] == p)
                mdl[p] = d;
    endtask

    task automatic readback();
        logic [7:0] ofs [8] = '{OFS_SINK_ASSIGN, OFS_SINK_FB, OFS_BOOST, OFS_PWM_CFG,
            OFS_BRT_LOW, OFS_BRT_HIGH, OFS_BANK_EN, 8'h30};
        foreach (ofs[i])
        begin
            u_host.rd(ofs[i], rdat, ok);
            `CHK("read ack", 1'b1, ok)
            `CHK("read data", mdl[ofs[i]], rdat)
        end
    endtask

    task automatic wait_level();
        int n = 0;
        while (cfg.bank_a_level !== 11'(lvl) && n < 10000)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (cfg.bank_a_level !== 11'(lvl))
        begin
            mismatches++;
            end_of_test();
        end
        `CHK("level", lvl, cfg.bank_a_level)
    endtask

    initial
    begin
        srst = 1'b1;
        lfsr_reg = 32'hF8F2;
        mismatches = 0;
        cmp_count = 0;
        @(posedge clk_sys);
        do_reset();
        `CHK("ramp map", {RAMP_CODE_RST, MAP_EXP_RST}, {cfg.ramp_code, cfg.map_exponential})
        `CHK("full scale", FS_CODE_RST, cfg.full_scale_code)
        wr(OFS_SINK_ASSIGN, 8'h04);
        wr(OFS_SINK_FB, 8'h03);
        wr(OFS_BOOST, 8'h04);
        wr(OFS_BANK_EN, 8'h01);
        wr(OFS_BRT_LOW, 8'h00);
        wr(8'h30, 8'hAA);
        `CHK("sink bank", 3'b100, cfg.sink_to_bank_b)
        `CHK("sink fb", 3'b011, cfg.sink_fb_en)
        `CHK("boost", 3'b100, {cfg.ovp_sel, cfg.sw_freq_1mhz})
        `CHK("bank en", 2'b01, {cfg.bank_b_en, cfg.bank_a_en})
        repeat (3)
        begin
            h = rnd();
            wr(OFS_BRT_HIGH, h);
            lvl = {h, 3'b000};
            wait_level();
        end
        wr(OFS_BOOST, 8'h02);
        `CHK("boost", 3'b010, {cfg.ovp_sel, cfg.sw_freq_1mhz})
        wr(OFS_PWM_CFG, 8'h0D);
        `CHK("pwm mode", 2'b11, {cfg.pwm_zero_det, cfg.pwm_act_high})
        `CHK("pwm banks", 2'b01, {cfg.pwm_bank_b_en, cfg.pwm_bank_a_en})
        repeat (3)
        begin
            l = rnd();
            h = rnd();
            wr(OFS_BRT_LOW, l);
            repeat (20) @(posedge clk_sys);
            `CHK("low held", lvl, cfg.bank_a_level)
            wr(OFS_BRT_HIGH, h);
            lvl = {h, l[2:0]};
            wait_level();
        end
        readback();
        u_host.rd2(OFS_BRT_LOW, rdat2, ok);
        `CHK("burst ack", 1'b1, ok)
        `CHK("burst read", {mdl[OFS_BRT_LOW][7:0], mdl[OFS_BRT_HIGH][7:0]}, rdat2)
        do_reset();
        `CHK("ovp reset", 2'h0, cfg.ovp_sel)
        readback();
        wr(OFS_BOOST, 8'h04);
        `CHK("ovp raised", 2'h2, cfg.ovp_sel)
        end_of_test();
    end
endmodule // testbench

bind lbbs_core lbbs_chk u_chk (.clk_sys(clk_sys), .srst(srst), .scl_in(scl_in),
    .sda_in(sda_in), .sda_o(sda_o), .sda_oe(sda_oe), .cfg(cfg));
